// *** scd_clk_src.sv ***
// Free-running source of the clock to be divided
`timescale 1ns/10ps
`default_nettype none
module scd_clk_src
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   output logic     div_clk_in
);
   logic [1:0] cnt_r;
   // Four system cycles a level, double the synchroniser's minimum
   always_ff @(posedge clk_sys)
   begin
      cnt_r      <= sys_rst ? 2'h0 : cnt_r + 2'h1;
      div_clk_in <= sys_rst ? 1'h0 : div_clk_in ^ (cnt_r == 2'h3);
   end
endmodule
`default_nettype wire

// *** scd_divider.sv ***
// Synchronous divide-by-2/4/8 generator with falling-edge hold and master clear
//
// Notes on behaviour
// (RULE_01) Clear released, clock high: first rise counts.
// (RULE_02) Clear released, clock low: second rise counts.
// (RULE_03) Hold taken on next falling clock edge.
// (RULE_04) Held dividers keep state on every edge.
// (RULE_05) Hold release acts at next falling edge.
// (RULE_06) Resume at next count, phases kept intact.
// (RULE_07) Divide by 2,4,8; clear overrides hold.
`timescale 1ns/10ps
`default_nettype none

module scd_divider
(
   input  wire logic clk_sys,
   input  wire logic sys_rst,
   input  wire logic div_clk_in,
   input  wire logic divider_clear,
   input  wire logic run_hold,
   output logic      half_rate_out,
   output logic      quarter_rate_out,
   output logic      eighth_rate_out_a
);

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   logic                      clk_s1_r;
   logic                      clk_s2_r;
   logic                      clk_d_r;
   logic                      clr_s1_r;
   logic                      clr_s2_r;
   logic                      hold_s1_r;
   logic                      hold_s2_r;
   logic                      clk_s1_nxt;
   logic                      clk_s2_nxt;
   logic                      clk_d_nxt;
   logic                      clr_s1_nxt;
   logic                      clr_s2_nxt;
   logic                      hold_s1_nxt;
   logic                      hold_s2_nxt;
   logic                      clk_rise;
   logic                      clk_fall;

   // First stages feed only the second stages, so metastability stays contained
   always_comb
   begin
      clk_s1_nxt  = div_clk_in;
      clk_s2_nxt  = clk_s1_r;
      clk_d_nxt   = clk_s2_r;
      clr_s1_nxt  = divider_clear;
      clr_s2_nxt  = clr_s1_r;
      hold_s1_nxt = run_hold;
      hold_s2_nxt = hold_s1_r;
   end

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         clk_s1_r  <= scd_pkg::SYNC_RST;
         clk_s2_r  <= scd_pkg::SYNC_RST;
         clk_d_r   <= scd_pkg::SYNC_RST;
         clr_s1_r  <= scd_pkg::CLR_RST;
         clr_s2_r  <= scd_pkg::CLR_RST;
         hold_s1_r <= scd_pkg::HOLD_RST;
         hold_s2_r <= scd_pkg::HOLD_RST;
      end
      else
      begin
         clk_s1_r  <= clk_s1_nxt;
         clk_s2_r  <= clk_s2_nxt;
         clk_d_r   <= clk_d_nxt;
         clr_s1_r  <= clr_s1_nxt;
         clr_s2_r  <= clr_s2_nxt;
         hold_s1_r <= hold_s1_nxt;
         hold_s2_r <= hold_s2_nxt;
      end
   end

   // Edges of the clock to be divided, seen only from synchronised copies.
   // Limitation: each input level must last at least two system cycles,
   // otherwise a whole pulse can slip between samples and a count is lost.
   assign clk_rise = clk_s2_r & ~clk_d_r;
   assign clk_fall = ~clk_s2_r & clk_d_r;

   // ------------------------------------------------------------
   // Hold flop, sampled on the falling edge only
   // ------------------------------------------------------------
   logic                      freeze_r;
   logic                      freeze_nxt;

   // Sampling while the clock is low avoids a runt advance at the boundary.
   // Clear drops any pending freeze, so a cleared divider never starts out held.
   always_comb
   begin
      freeze_nxt = freeze_r;
      if (clr_s2_r)
      begin
         freeze_nxt = scd_pkg::HOLD_RST;             // [RULE_07]
      end
      else if (clk_fall)
      begin
         freeze_nxt = hold_s2_r;                     // [RULE_03] [RULE_05]
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         freeze_r <= scd_pkg::HOLD_RST;
      end
      else
      begin
         freeze_r <= freeze_nxt;
      end
   end

   // ------------------------------------------------------------
   // Start-up sequencing after clear
   // ------------------------------------------------------------
   scd_pkg::scd_state_t       st_r;
   scd_pkg::scd_state_t       st_nxt;

   // Released while high runs at once; released while low spends one rise arming.
   // Trade-off: the level is judged from the synchronised copy, so a release within
   // a cycle or two of an input edge is classed by the delayed level, never a runt.
   always_comb
   begin
      st_nxt = st_r;
      unique case (st_r)
         scd_pkg::SCD_CLEARED:
         begin
            if (!clr_s2_r)
            begin
               st_nxt = clk_s2_r ? scd_pkg::SCD_RUNNING   // [RULE_01]
                                 : scd_pkg::SCD_ARMING;   // [RULE_02]
            end
         end
         scd_pkg::SCD_ARMING:
         begin
            if (clr_s2_r)
            begin
               st_nxt = scd_pkg::SCD_CLEARED;
            end
            else if (clk_rise)
            begin
               st_nxt = scd_pkg::SCD_RUNNING;        // [RULE_02]
            end
         end
         scd_pkg::SCD_RUNNING:
         begin
            if (clr_s2_r)
            begin
               st_nxt = scd_pkg::SCD_CLEARED;
            end
         end
         default:
         begin
            st_nxt = scd_pkg::SCD_CLEARED;
         end
      endcase
   end

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         st_r <= scd_pkg::SCD_CLEARED;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // ------------------------------------------------------------
   // Divider chain
   // ------------------------------------------------------------
   logic [scd_pkg::DIV_W-1:0] cnt_r;
   logic [scd_pkg::DIV_W-1:0] cnt_nxt;

   // One binary count gives all three stages on a shared edge, so they stay aligned.
   // Hold only gates the increment; only clear reloads the count, so hold skips no state.
   always_comb
   begin
      cnt_nxt = cnt_r;
      if (clr_s2_r)
      begin
         cnt_nxt = scd_pkg::CNT_RST;                 // [RULE_07]
      end
      else if (clk_rise && (st_r == scd_pkg::SCD_RUNNING) && !freeze_r) // [RULE_04]
      begin
         cnt_nxt = cnt_r + 3'h1;                     // [RULE_06] [RULE_07]
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         cnt_r <= scd_pkg::CNT_RST;
      end
      else
      begin
         cnt_r <= cnt_nxt;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   // Outputs are the counter flops themselves; no gate sits after them,
   // so all three divided clocks leave on the same system edge
   assign half_rate_out     = cnt_r[scd_pkg::BIT_HALF];
   assign quarter_rate_out  = cnt_r[scd_pkg::BIT_QUARTER];
   assign eighth_rate_out_a = cnt_r[scd_pkg::BIT_EIGHTH];

endmodule

`default_nettype wire

// *** scd_divider_properties.sv ***
// Port checker for the 2/4/8 clock divider
`timescale 1ns/10ps
`default_nettype none
module scd_divider_chk
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic div_clk_in,
   input wire logic divider_clear,
   input wire logic run_hold,
   input wire logic half_rate_out,
   input wire logic quarter_rate_out,
   input wire logic eighth_rate_out_a
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   logic [2:0] q;
   logic       s1_r, s2_r, s3_r;
   logic [4:0] hold_r;
   assign q = {eighth_rate_out_a, quarter_rate_out, half_rate_out};
   // Mirror of the pin synchroniser and a saturating hold-length count, restarted by clear
   always_ff @(posedge clk_sys)
   begin
      s1_r   <= div_clk_in;
      s2_r   <= s1_r;
      s3_r   <= s2_r;
      hold_r <= (sys_rst || divider_clear || !run_hold) ? 5'h0
                : hold_r + {4'h0, hold_r != 5'h1F};
   end
   property p_start; $changed(q) |-> $past(s2_r && !s3_r) || q == 3'h0; endproperty
   a_start: assert property (p_start) else $error("count moved off a rise");
   property p_arm; $fell(divider_clear) && !div_clk_in |-> ##2 (q == 3'h0) [*6]; endproperty
   a_arm: assert property (p_arm) else $error("early start");
   property p_take; hold_r == 5'h10 && !divider_clear |-> $stable(q) [*4]; endproperty
   a_take: assert property (p_take) else $error("hold not taken");
   property p_keep; hold_r > 5'h10 |-> $stable(q); endproperty
   a_keep: assert property (p_keep) else $error("moved while frozen");
   property p_thaw; $fell(run_hold) && hold_r >= 5'h10 |-> $stable(q) [*3]; endproperty
   a_thaw: assert property (p_thaw) else $error("thawed early");
   property p_next;
      $changed(q) && !$past(divider_clear, 2) && !$past(divider_clear, 3)
      |-> q == $past(q) + 3'h1;
   endproperty
   a_next: assert property (p_next) else $error("count skipped");
   property p_clr; divider_clear [*3] |=> q == 3'h0; endproperty
   a_clr: assert property (p_clr) else $error("clear ignored");
   c_hold: cover property (hold_r == 5'h10);
   c_arm: cover property ($fell(divider_clear) && !div_clk_in);
   c_top: cover property (q == 3'h7);
endmodule
bind scd_divider scd_divider_chk u_chk (.clk_sys, .sys_rst, .div_clk_in, .divider_clear,
   .run_hold, .half_rate_out, .quarter_rate_out, .eighth_rate_out_a);
`default_nettype wire

// *** scd_pkg.sv ***
// Shared constants for the synchronous 2/4/8 clock divider
package scd_pkg;

   // ------------------------------------------------------------
   // Divider geometry and reset values
   // ------------------------------------------------------------
   localparam int          DIV_W       = 3;
   localparam logic [2:0]  CNT_RST     = 3'h0;
   localparam int          BIT_HALF    = 0;
   localparam int          BIT_QUARTER = 1;
   localparam int          BIT_EIGHTH  = 2;

   // ------------------------------------------------------------
   // Pin synchroniser reset levels
   // ------------------------------------------------------------
   localparam logic        SYNC_RST    = 1'h0;
   localparam logic        CLR_RST     = 1'h1;
   localparam logic        HOLD_RST    = 1'h0;

   // ------------------------------------------------------------
   // Start-up sequence after a clear
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      SCD_CLEARED = 3'h1,
      SCD_ARMING  = 3'h2,
      SCD_RUNNING = 3'h4
   } scd_state_t;

endpackage

// *** scd_tb.sv ***
// Self-checking bench for the 2/4/8 clock divider
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic       clk_sys, sys_rst, divider_clear, run_hold, div_clk_in;
   logic       half_rate_out, quarter_rate_out, eighth_rate_out_a;
   logic [2:0] q;
   int         failures, total_checks;
   assign q = {eighth_rate_out_a, quarter_rate_out, half_rate_out};
   scd_clk_src u_scd_clk_src (.clk_sys, .sys_rst, .div_clk_in);
   scd_divider u_scd_divider (.clk_sys, .sys_rst, .div_clk_in, .divider_clear, .run_hold,
      .half_rate_out, .quarter_rate_out, .eighth_rate_out_a);
   task automatic check(logic [2:0] seen, logic [2:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("wrong value at %0t: %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic final_report();
      if (failures == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // Wait n input rises, then let the 2-3 cycle sync latency pass
   task automatic rises_check(int n, logic [2:0] exp);
      repeat (n) @(posedge div_clk_in);
      repeat (4) @(posedge clk_sys);
      check(q, exp);
   endtask
   // Wait until just after an input clock edge of the given level, so the caller can drive a control pin
   task automatic after_edge(logic lvl);
      if (lvl)
         @(posedge div_clk_in);
      else
         @(negedge div_clk_in);
      @(posedge clk_sys);
   endtask
   task automatic t_release_high();
      after_edge(1'h1);
      divider_clear <= 1'h0;
      rises_check(3, 3'h3);
   endtask
   task automatic t_release_low();
      divider_clear <= 1'h1;
      after_edge(1'h0);
      divider_clear <= 1'h0;
      rises_check(3, 3'h2);
   endtask
   // Hold set after a fall lets one rise through; release after a fall waits a full period
   task automatic t_hold();
      after_edge(1'h0);
      run_hold <= 1'h1;
      rises_check(3, 3'h3);
      after_edge(1'h0);
      run_hold <= 1'h0;
      rises_check(2, 3'h4);
      rises_check(3, 3'h7);
   endtask
   task automatic t_clear();
      run_hold      <= 1'h1;
      divider_clear <= 1'h1;
      repeat (5) @(posedge clk_sys);
      check(q, 3'h0);
   endtask
   initial
   begin
      clk_sys = 1'h0;
      forever #10 clk_sys = ~clk_sys;
   end
   initial
   begin
      repeat (3000) @(posedge clk_sys);
      failures++;
      final_report();
   end
   initial
   begin
      sys_rst       = 1'h1;
      divider_clear = 1'h1;
      run_hold      = 1'h0;
      repeat (2) @(posedge clk_sys);
      sys_rst <= 1'h0;
      t_release_high();
      t_release_low();
      t_hold();
      t_clear();
      final_report();
   end
endmodule
`default_nettype wire
